// [common/pllaux_regs.svh]
// Purpose: Constants for the PLL and auxiliary output configuration fields
// Assumes: Byte-wide configuration writes, one field group per strobe
// Notes: Defaults apply at synchronous reset
`ifndef PLLAUX_REGS_SVH
`define PLLAUX_REGS_SVH
`define PLLAUX_PWR_DEFAULT 1'h0
`define PLLAUX_FMT_DEFAULT 1'h0
`define PLLAUX_OFS_EN_DEFAULT 1'h0
`define PLLAUX_OFS_DEFAULT 5'h00
`define PLLAUX_OFS_MAX 5'h1f
`define PLLAUX_CP_DEFAULT 5'h18
`define PLLAUX_AMP_DEFAULT 2'h0
`define PLLAUX_FMT_LVDS 1'h0
`define PLLAUX_FMT_LVPECL 1'h1
`define PLLAUX_AMP_250 2'h0
`define PLLAUX_AMP_500A 2'h1
`define PLLAUX_AMP_500B 2'h2
`define PLLAUX_AMP_750 2'h3
`define PLLAUX_SWING_OFF 2'h0
`define PLLAUX_SWING_250 2'h1
`define PLLAUX_SWING_500 2'h2
`define PLLAUX_SWING_750 2'h3
`define PLLAUX_UNIT_BASE 6'h01
`endif

// [common/pllaux_pkg.sv]
// Purpose: Types for the PLL and auxiliary output configuration fields
// Assumes: Used together with pllaux_regs.svh
// Notes: Field groups travel as packed structs
package pllaux_pkg;
    typedef struct packed {
        logic power_up;
        logic format_sel;
        logic offset_enable;
        logic [4:0] offset_code;
    } pllaux_ctl_t;
    typedef struct packed {
        logic [1:0] amplitude_code;
        logic [4:0] pump_current_code;
    } pllaux_amp_t;
endpackage

// [rtl/pllaux_field.sv]
// Purpose: One stored configuration field with reset default
// Assumes: Synchronous active-high reset
// Notes: Holds its value until the write enable is seen
`timescale 1ns/10ps
`default_nettype none
module pllaux_field #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] value
);
    logic [W-1:0] value_r;
    logic [W-1:0] value_nxt;

    always_comb
    begin
        value_nxt = value_r;
        if (wr_en)
        begin
            value_nxt = wr_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            value_r <= RST_VAL;
        end
        else
        begin
            value_r <= value_nxt;
        end
    end

    assign value = value_r;
endmodule // pllaux_field
`default_nettype wire

// [rtl/pllaux_cfg.sv]
// Purpose: Configuration fields for first-stage PLL offset, second-stage
//   charge pump current and the auxiliary clock output
// Assumes: Write strobes and data synchronous to ref_clk
// Notes: Analog controls come straight from flip-flops
// Behaviour
// - Aux output powered only when power bit set
// - Format bit selects LVDS or LVPECL
// - Offset applied only while enable set
// - Offset code is unsigned 0.9 degree steps
// - Largest offset code 31, 27.9 degrees
// - Pump current 200uA times code plus one
// - Amplitude code maps to 250/500/750 mV
`timescale 1ns/10ps
`default_nettype none
`include "pllaux_regs.svh"
module pllaux_cfg
    import pllaux_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ctl_wr,
    input wire pllaux_ctl_t ctl_wdata,
    input wire logic amp_wr,
    input wire pllaux_amp_t amp_wdata,
    output pllaux_ctl_t ctl_rdata,
    output pllaux_amp_t amp_rdata,
    output logic aux_out_enable,
    output logic aux_out_format_sel,
    output logic [1:0] aux_out_swing,
    output logic pll1_offset_enable,
    output logic [4:0] pll1_offset_applied,
    output logic [4:0] pll2_pump_current_code,
    output logic [5:0] pll2_pump_units
);
    localparam pllaux_ctl_t CTL_RST = '{`PLLAUX_PWR_DEFAULT,
        `PLLAUX_FMT_DEFAULT, `PLLAUX_OFS_EN_DEFAULT, `PLLAUX_OFS_DEFAULT};
    localparam pllaux_amp_t AMP_RST = '{`PLLAUX_AMP_DEFAULT,
        `PLLAUX_CP_DEFAULT};

    pllaux_ctl_t ctl_q;
    pllaux_amp_t amp_q;

    // Stored fields hold until the next write of their group
    pllaux_field #(.W(8), .RST_VAL(CTL_RST)) u_ctl (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(ctl_wr),
        .wr_data(ctl_wdata),
        .value(ctl_q)
    );

    pllaux_field #(.W(7), .RST_VAL(AMP_RST)) u_amp (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(amp_wr),
        .wr_data(amp_wdata),
        .value(amp_q)
    );

    // Read-back group: same register stage as the analog controls
    pllaux_ctl_t ctl_rdata_r;
    pllaux_ctl_t ctl_rdata_nxt;
    pllaux_amp_t amp_rdata_r;
    pllaux_amp_t amp_rdata_nxt;

    always_comb
    begin
        ctl_rdata_nxt = ctl_q;
        amp_rdata_nxt = amp_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctl_rdata_r <= CTL_RST;
            amp_rdata_r <= AMP_RST;
        end
        else
        begin
            ctl_rdata_r <= ctl_rdata_nxt;
            amp_rdata_r <= amp_rdata_nxt;
        end
    end

    // Auxiliary output group
    logic aux_out_enable_r;
    logic aux_out_enable_nxt;
    logic aux_out_format_sel_r;
    logic aux_out_format_sel_nxt;
    logic [1:0] aux_out_swing_r;
    logic [1:0] aux_out_swing_nxt;

    always_comb
    begin
        aux_out_enable_nxt = ctl_q.power_up;
        aux_out_format_sel_nxt = ctl_q.format_sel;
        // Same swing map in either format
        case (amp_q.amplitude_code)
            `PLLAUX_AMP_250: aux_out_swing_nxt = `PLLAUX_SWING_250;
            `PLLAUX_AMP_500A: aux_out_swing_nxt = `PLLAUX_SWING_500;
            `PLLAUX_AMP_500B: aux_out_swing_nxt = `PLLAUX_SWING_500;
            `PLLAUX_AMP_750: aux_out_swing_nxt = `PLLAUX_SWING_750;
            default: aux_out_swing_nxt = `PLLAUX_SWING_250;
        endcase
        // Swing reads off while powered down; code kept for read-back
        if (!ctl_q.power_up)
        begin
            aux_out_swing_nxt = `PLLAUX_SWING_OFF;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            aux_out_enable_r <= `PLLAUX_PWR_DEFAULT;
            aux_out_format_sel_r <= `PLLAUX_FMT_LVDS;
            aux_out_swing_r <= `PLLAUX_SWING_OFF;
        end
        else
        begin
            aux_out_enable_r <= aux_out_enable_nxt;
            aux_out_format_sel_r <= aux_out_format_sel_nxt;
            aux_out_swing_r <= aux_out_swing_nxt;
        end
    end

    // First-stage offset group
    logic pll1_offset_enable_r;
    logic pll1_offset_enable_nxt;
    logic [4:0] pll1_offset_applied_r;
    logic [4:0] pll1_offset_applied_nxt;

    always_comb
    begin
        pll1_offset_enable_nxt = ctl_q.offset_enable;
        // Five-bit field cannot exceed the 27.9 degree maximum
        pll1_offset_applied_nxt = `PLLAUX_OFS_DEFAULT;
        if (ctl_q.offset_enable)
        begin
            pll1_offset_applied_nxt = ctl_q.offset_code;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pll1_offset_enable_r <= `PLLAUX_OFS_EN_DEFAULT;
            pll1_offset_applied_r <= `PLLAUX_OFS_DEFAULT;
        end
        else
        begin
            pll1_offset_enable_r <= pll1_offset_enable_nxt;
            pll1_offset_applied_r <= pll1_offset_applied_nxt;
        end
    end

    // Second-stage charge pump group
    localparam logic [5:0] UNITS_RST = {1'h0, `PLLAUX_CP_DEFAULT}
        + `PLLAUX_UNIT_BASE;
    logic [4:0] pll2_pump_current_code_r;
    logic [4:0] pll2_pump_current_code_nxt;
    logic [5:0] pll2_pump_units_r;
    logic [5:0] pll2_pump_units_nxt;

    always_comb
    begin
        pll2_pump_current_code_nxt = amp_q.pump_current_code;
        // Unit count in 200 uA steps: code plus one, 1..32
        pll2_pump_units_nxt = {1'h0, amp_q.pump_current_code}
            + `PLLAUX_UNIT_BASE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pll2_pump_current_code_r <= `PLLAUX_CP_DEFAULT;
            pll2_pump_units_r <= UNITS_RST;
        end
        else
        begin
            pll2_pump_current_code_r <= pll2_pump_current_code_nxt;
            pll2_pump_units_r <= pll2_pump_units_nxt;
        end
    end

    assign ctl_rdata = ctl_rdata_r;
    assign amp_rdata = amp_rdata_r;
    assign aux_out_enable = aux_out_enable_r;
    assign aux_out_format_sel = aux_out_format_sel_r;
    assign aux_out_swing = aux_out_swing_r;
    assign pll1_offset_enable = pll1_offset_enable_r;
    assign pll1_offset_applied = pll1_offset_applied_r;
    assign pll2_pump_current_code = pll2_pump_current_code_r;
    assign pll2_pump_units = pll2_pump_units_r;
endmodule // pllaux_cfg
`default_nettype wire

// [verification/pllaux_cfg_props.sv]
// Purpose: Port properties of pllaux_cfg
// Assumes: rst synchronous, active high
// Notes: Outputs follow a write strobe two edges later
`timescale 1ns/10ps
`default_nettype none
module pllaux_cfg_props
    import pllaux_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ctl_wr,
    input wire pllaux_ctl_t ctl_wdata,
    input wire logic amp_wr,
    input wire pllaux_amp_t amp_wdata,
    input wire pllaux_ctl_t ctl_rdata,
    input wire pllaux_amp_t amp_rdata,
    input wire logic aux_out_enable,
    input wire logic aux_out_format_sel,
    input wire logic [1:0] aux_out_swing,
    input wire logic pll1_offset_enable,
    input wire logic [4:0] pll1_offset_applied,
    input wire logic [4:0] pll2_pump_current_code,
    input wire logic [5:0] pll2_pump_units
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ctl_readback: assert property (
        ctl_wr |-> ##2 ctl_rdata == $past(ctl_wdata, 2))
        else $error("ctl read-back wrong");
    a_amp_readback: assert property (
        amp_wr |-> ##2 amp_rdata == $past(amp_wdata, 2))
        else $error("amp read-back wrong");
    a_ctl_hold: assert property (
        !ctl_wr |-> ##2 $stable(ctl_rdata))
        else $error("ctl fields moved without write");
    a_amp_hold: assert property (
        !amp_wr |-> ##2 $stable(amp_rdata))
        else $error("amp fields moved without write");
    a_reset_values: assert property (disable iff (1'b0)
        rst |=> ctl_rdata == 8'h00 && amp_rdata == 7'h18)
        else $error("reset defaults wrong");
    a_power_state: assert property (
        aux_out_enable == ctl_rdata.power_up)
        else $error("power state differs from field");
    a_format_sel: assert property (
        aux_out_format_sel == ctl_rdata.format_sel)
        else $error("format differs from field");
    a_offset_gate: assert property (
        pll1_offset_applied == (ctl_rdata.offset_enable ?
        ctl_rdata.offset_code : 5'h00) &&
        pll1_offset_enable == ctl_rdata.offset_enable)
        else $error("applied offset wrong");
    a_pump_units: assert property (
        pll2_pump_current_code == amp_rdata.pump_current_code &&
        pll2_pump_units == {1'b0, pll2_pump_current_code} + 6'h01)
        else $error("pump units wrong");
    a_swing_map: assert property (
        aux_out_swing == (!aux_out_enable ? 2'h0 :
        amp_rdata.amplitude_code == 2'h0 ? 2'h1 :
        amp_rdata.amplitude_code == 2'h3 ? 2'h3 : 2'h2))
        else $error("swing code wrong");
endmodule // pllaux_cfg_props
bind pllaux_cfg pllaux_cfg_props chk_u (.ref_clk, .rst, .ctl_wr,
    .ctl_wdata, .amp_wr, .amp_wdata, .ctl_rdata, .amp_rdata,
    .aux_out_enable, .aux_out_format_sel, .aux_out_swing,
    .pll1_offset_enable, .pll1_offset_applied,
    .pll2_pump_current_code, .pll2_pump_units);
`default_nettype wire

// [verification/pllaux_cfg_test.sv]
// Purpose: Directed bench for pllaux_cfg
// Assumes: Two write strobes, outputs settle two edges after a write
// Notes: Expected values are worked out here, not read back
`timescale 1ns/10ps
`default_nettype none
module pllaux_cfg_test
    import pllaux_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ctl_wr = 1'b0;
    logic amp_wr = 1'b0;
    pllaux_ctl_t ctl_wdata = '0;
    pllaux_amp_t amp_wdata = '0;
    pllaux_ctl_t ctl_rdata;
    pllaux_amp_t amp_rdata;
    logic aux_out_enable, aux_out_format_sel, pll1_offset_enable;
    logic [1:0] aux_out_swing;
    logic [4:0] pll1_offset_applied, pll2_pump_current_code;
    logic [5:0] pll2_pump_units;
    logic [7:0] sw_tab [4] = '{8'h01, 8'h02, 8'h02, 8'h03};
    int n_fail = 0;
    int check_count = 0;
    always #10 ref_clk = ~ref_clk;
    pllaux_cfg dut_u (.ref_clk, .rst, .ctl_wr, .ctl_wdata, .amp_wr,
        .amp_wdata, .ctl_rdata, .amp_rdata, .aux_out_enable,
        .aux_out_format_sel, .aux_out_swing, .pll1_offset_enable,
        .pll1_offset_applied, .pll2_pump_current_code,
        .pll2_pump_units);
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Both data buses move on purpose; only the strobed group may store
    task automatic wr(input logic is_ctl, input logic [7:0] d);
        @(posedge ref_clk);
        ctl_wr <= is_ctl;
        amp_wr <= !is_ctl;
        ctl_wdata <= d;
        amp_wdata <= d[6:0];
        @(posedge ref_clk);
        ctl_wr <= 1'b0;
        amp_wr <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk_dflt();
        chk("ctl_rdata", ctl_rdata, 8'h00);
        chk("amp_rdata", amp_rdata, 8'h18);
        chk("swing", aux_out_swing, 8'h00);
        chk("units", pll2_pump_units, 8'h19);
        chk("pump_code", pll2_pump_current_code, 8'h18);
        chk("offset_en", pll1_offset_enable, 8'h00);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk_dflt();
        $display("test defaults done");
        wr(1'b1, 8'hff);
        chk("ctl_rdata", ctl_rdata, 8'hff);
        chk("enable", aux_out_enable, 8'h01);
        chk("format", aux_out_format_sel, 8'h01);
        chk("applied", pll1_offset_applied, 8'h1f);
        chk("offset_en", pll1_offset_enable, 8'h01);
        for (int a = 0; a < 4; a++)
        begin
            wr(1'b0, {1'b0, 2'(a), a[0] ? 5'h1f : 5'h00});
            chk("swing", aux_out_swing, sw_tab[a]);
            chk("units", pll2_pump_units, a[0] ? 8'h20 : 8'h01);
            chk("pump_code", pll2_pump_current_code,
                a[0] ? 8'h1f : 8'h00);
        end
        $display("test fields done");
        wr(1'b1, 8'h4a);
        chk("applied", pll1_offset_applied, 8'h00);
        chk("offset_en", pll1_offset_enable, 8'h00);
        chk("swing", aux_out_swing, 8'h00);
        repeat (5) @(posedge ref_clk);
        #1;
        chk("ctl_rdata", ctl_rdata, 8'h4a);
        chk("amp_rdata", amp_rdata, 8'h7f);
        $display("test hold done");
        // Software keeps the offset at zero while enabled
        wr(1'b1, 8'ha0);
        chk("offset_en", pll1_offset_enable, 8'h01);
        chk("applied", pll1_offset_applied, 8'h00);
        chk("swing", aux_out_swing, 8'h03);
        $display("test zero offset done");
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk_dflt();
        $display("test reset done");
        conclude();
    end
    // Run needs under 100 cycles; allow twice that
    initial
    begin
        #4000;
        n_fail++;
        conclude();
    end
endmodule // pllaux_cfg_test
`default_nettype wire
